// file: hw/brtc_host_port.sv
`timescale 1ns/100ps
`default_nettype none
module brtc_host_port (
    // clock and reset
    input  wire  logic                         clk_sys,
    input  wire  logic                         rst_n,
    // memory strobes and buses
    input  wire  logic                         ce_n,
    input  wire  logic                         oe_n,
    input  wire  logic                         we_n,
    input  wire  logic [brtc_pkg::ADDR_W-1:0]  address_lines,
    input  wire  logic [brtc_pkg::DATA_W-1:0]  dq_in,
    output logic       [brtc_pkg::DATA_W-1:0]  dq_out,
    output logic                               dq_oe,
    // timekeeping and supervisor inputs
    input  wire  logic                         sec_tick,
    input  wire  logic                         pwr_fail,
    // interrupt pin and processor reset
    output logic                               int_out,
    output logic                               int_oe,
    output logic                               proc_rst_n
);
    import brtc_pkg::*;

    // ***************************************************************
    // pin synchronisers
    // ***************************************************************
    brtc_pins_t pin_raw;
    brtc_pins_t pin_m_r;   // first stage, read only by pin_s_r
    brtc_pins_t pin_s_r;   // second stage
    brtc_pins_t pin_q_r;   // previous value, for edge detection

    assign pin_raw = '{ce_n: ce_n, oe_n: oe_n, we_n: we_n, addr: address_lines,
                       dq: dq_in, sec_tick: sec_tick, pwr_fail: pwr_fail};

    // every pin is asynchronous to clk_sys
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pin_m_r <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
            pin_s_r <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
            pin_q_r <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
        end else begin
            pin_m_r <= pin_raw;
            pin_s_r <= pin_m_r;
            pin_q_r <= pin_s_r;
        end
    end

    // ***************************************************************
    // access decode
    // ***************************************************************
    logic [ADDR_W-1:0] addr_lat_r;
    wire               ce_fall  = pin_q_r.ce_n & ~pin_s_r.ce_n;
    wire               selected = ~pin_s_r.ce_n;
    // a write ends when write enable or chip select rises
    wire               wr_go    = ~pin_q_r.ce_n & ~pin_q_r.we_n
                                  & (pin_s_r.we_n | pin_s_r.ce_n);
    // a read counts as done when chip select rises after oe low
    wire               rd_done  = ~pin_q_r.ce_n & pin_q_r.we_n & ~pin_q_r.oe_n
                                  & pin_s_r.ce_n;
    wire               top16    = (addr_lat_r[14:4] == REG_PAGE);
    wire [3:0]         ridx     = addr_lat_r[3:0];
    wire [7:0]         wdat     = pin_q_r.dq;
    wire               reg_we   = wr_go & top16;
    brtc_wr_t          mem_wr;

    assign mem_wr = '{en: wr_go & ~top16, addr: addr_lat_r, data: wdat};

    // address is only taken on the falling edge of chip select
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            addr_lat_r <= '0;
        end else if (ce_fall) begin
            addr_lat_r <= pin_s_r.addr;
        end
    end

    // ***************************************************************
    // register file
    // ***************************************************************
    logic [7:0] flags_r, user_r, al_sec_r, al_min_r, al_hour_r, al_date_r;
    logic [7:0] int_cfg_r, wdog_r, osc_cal_r;
    logic [7:0] sec_r, min_r, hour_r, wday_r, date_r, month_r, year_r;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction : bcd_inc

    // leap when year mod 4 is zero; 2000 counts as leap, true through 2099
    wire       leap    = year_r[4] ? (year_r[3:0] == 4'h2 || year_r[3:0] == 4'h6)
                                   : (year_r[3:0] == 4'h0 || year_r[3:0] == 4'h4
                                      || year_r[3:0] == 4'h8);
    wire [7:0] dim     = (month_r == 8'h02) ? (leap ? 8'h29 : 8'h28)
                       : (month_r == 8'h04 || month_r == 8'h06 || month_r == 8'h09
                          || month_r == 8'h11) ? 8'h30 : 8'h31;

    // a tick waits while a host write is committing, so none is lost
    logic      tick_pend_r;
    wire       tick_ev    = pin_s_r.sec_tick & ~pin_q_r.sec_tick
                            & ~osc_cal_r[BIT_OSC_OFF] & ~flags_r[BIT_WR_HALT];
    wire       tick_apply = (tick_pend_r | tick_ev) & ~reg_we;
    wire       c_min      = tick_apply & (sec_r == BCD_59);
    wire       c_hour     = c_min & (min_r == BCD_59);
    wire       c_day      = c_hour & (hour_r == BCD_23);
    wire       c_month    = c_day & (date_r == dim);
    wire       c_year     = c_month & (month_r == BCD_12);
    wire       c_cent     = c_year & (year_r == BCD_99);

    // time counters; a host write replaces the value, unused bits stay zero
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            {sec_r, min_r, hour_r, year_r} <= {4{RST_ZERO}};
            {wday_r, date_r, month_r}      <= {3{RST_ONE}};
            tick_pend_r                    <= 1'b0;
        end else begin
            tick_pend_r <= (tick_pend_r | tick_ev) & reg_we;
            if (reg_we && ridx == OFS_SECONDS[3:0]) begin
                sec_r <= wdat & MASK_SEC_MIN;
            end else if (tick_apply) begin
                sec_r <= c_min ? RST_ZERO : bcd_inc(sec_r);
            end
            if (reg_we && ridx == OFS_MINUTES[3:0]) begin
                min_r <= wdat & MASK_SEC_MIN;
            end else if (c_min) begin
                min_r <= c_hour ? RST_ZERO : bcd_inc(min_r);
            end
            if (reg_we && ridx == OFS_HOURS[3:0]) begin
                hour_r <= wdat & MASK_HR_DATE;
            end else if (c_hour) begin
                hour_r <= c_day ? RST_ZERO : bcd_inc(hour_r);
            end
            if (reg_we && ridx == OFS_WEEKDAY[3:0]) begin
                wday_r <= wdat & MASK_WEEKDAY;
            end else if (c_day) begin
                wday_r <= (wday_r == DAY_LAST) ? RST_ONE : bcd_inc(wday_r);
            end
            if (reg_we && ridx == OFS_DATE[3:0]) begin
                date_r <= wdat & MASK_HR_DATE;
            end else if (c_day) begin
                date_r <= c_month ? RST_ONE : bcd_inc(date_r);
            end
            if (reg_we && ridx == OFS_MONTH[3:0]) begin
                month_r <= wdat & MASK_MONTH;
            end else if (c_month) begin
                month_r <= c_year ? RST_ONE : bcd_inc(month_r);
            end
            if (reg_we && ridx == OFS_YEAR[3:0]) begin
                year_r <= wdat;
            end else if (c_year) begin
                year_r <= c_cent ? RST_ZERO : bcd_inc(year_r);
            end
        end
    end

    // control bytes; rst_n stands for the load of the stored settings
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            {user_r, al_sec_r, al_min_r, al_hour_r, al_date_r} <= {5{RST_ZERO}};
            {int_cfg_r, wdog_r, osc_cal_r}                      <= {3{RST_ZERO}};
        end else if (reg_we) begin
            case (ridx)
                OFS_USER[3:0]:    user_r    <= wdat;
                OFS_AL_SEC[3:0]:  al_sec_r  <= wdat;
                OFS_AL_MIN[3:0]:  al_min_r  <= wdat;
                OFS_AL_HOUR[3:0]: al_hour_r <= wdat & MASK_AL_HD;
                OFS_AL_DATE[3:0]: al_date_r <= wdat & MASK_AL_HD;
                OFS_INT_CFG[3:0]: int_cfg_r <= wdat & MASK_INT_CFG;
                OFS_WDOG[3:0]:    wdog_r    <= wdat & MASK_WDOG;
                OFS_OSC_CAL[3:0]: osc_cal_r <= wdat & MASK_OSC_CAL;
                default:          ;
            endcase
        end
    end

    // ***************************************************************
    // alarm, watchdog, power fail and flags
    // ***************************************************************
    logic       alarm_chk_r;
    logic [5:0] wd_cnt_r;
    logic [7:0] rst_cnt_r;
    wire        al_hit   = (al_sec_r[BIT_NO_MATCH]  | (al_sec_r[6:0]  == sec_r[6:0]))
                         & (al_min_r[BIT_NO_MATCH]  | (al_min_r[6:0]  == min_r[6:0]))
                         & (al_hour_r[BIT_NO_MATCH] | (al_hour_r[6:0] == hour_r[6:0]))
                         & (al_date_r[BIT_NO_MATCH] | (al_date_r[6:0] == date_r[6:0]));
    wire        set_af   = alarm_chk_r & al_hit;
    wire        wd_kick  = reg_we & (ridx == OFS_WDOG[3:0]) & wdat[BIT_WD_STRB];
    wire        wd_fire  = tick_apply & (wdog_r[5:0] != 6'h00)
                           & (wd_cnt_r + 6'h01 == wdog_r[5:0]) & ~wd_kick;
    wire        set_pf   = pin_s_r.pwr_fail & ~pin_q_r.pwr_fail;
    wire        flag_clr = rd_done & top16 & (ridx == OFS_FLAGS[3:0]);
    wire [3:0]  hw_set   = {wd_fire, set_af, set_pf, c_cent};
    wire        wd_to_rst = wd_fire & ~int_cfg_r[BIT_WD_IRQ_EN];

    // watchdog counts seconds; the strobe restarts it
    always_ff @(posedge clk_sys) begin
        if (!rst_n || wd_kick || wd_fire) begin
            wd_cnt_r <= 6'h00;
        end else if (tick_apply) begin
            wd_cnt_r <= wd_cnt_r + 6'h01;
        end
    end

    // event flags clear on a finished read; a set in the same cycle wins
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            flags_r     <= RST_ZERO;
            alarm_chk_r <= 1'b0;
        end else begin
            alarm_chk_r  <= tick_apply;
            flags_r[7:4] <= hw_set | (flags_r[7:4] & {4{~flag_clr}});
            if (reg_we && ridx == OFS_FLAGS[3:0]) begin
                flags_r[3:0] <= wdat[3:0] & MASK_FLAGS_SW[3:0];
            end
        end
    end

    // ***************************************************************
    // interrupt pin and processor reset
    // ***************************************************************
    wire irq_cond = (int_cfg_r[BIT_WD_IRQ_EN] & flags_r[BIT_WDF])
                  | (int_cfg_r[BIT_AL_IRQ_EN] & flags_r[BIT_AF])
                  | (int_cfg_r[BIT_PF_IRQ_EN] & flags_r[BIT_PF]);
    wire int_act  = int_cfg_r[BIT_HI_LO] ? int_out : int_oe;

    // open-drain mode only pulls low, so it never drives a high level
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            int_out <= 1'b0;
            int_oe  <= 1'b0;
        end else begin
            int_out <= int_cfg_r[BIT_HI_LO] & irq_cond;
            int_oe  <= int_cfg_r[BIT_HI_LO] | irq_cond;
        end
    end

    // reset pulse of fixed width when the watchdog is not routed to irq
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rst_cnt_r  <= 8'h00;
            proc_rst_n <= 1'b1;
        end else begin
            rst_cnt_r  <= wd_to_rst ? PROC_RST_LOAD
                        : (rst_cnt_r != 8'h00) ? rst_cnt_r - 8'h01 : 8'h00;
            proc_rst_n <= ~(wd_to_rst | (rst_cnt_r > 8'h01));
        end
    end

    // ***************************************************************
    // read path
    // ***************************************************************
    logic [7:0] mem_rd;
    logic [7:0] reg_rd;

    brtc_mem u_mem (
        .clk_sys   (clk_sys),
        .wr        (mem_wr),
        .rd_addr   (addr_lat_r),
        .rd_data_r (mem_rd)
    );

    // watchdog strobe bit is write-only and reads zero
    always_comb begin
        case (ridx)
            OFS_FLAGS[3:0]:   reg_rd = flags_r;
            OFS_USER[3:0]:    reg_rd = user_r;
            OFS_AL_SEC[3:0]:  reg_rd = al_sec_r;
            OFS_AL_MIN[3:0]:  reg_rd = al_min_r;
            OFS_AL_HOUR[3:0]: reg_rd = al_hour_r;
            OFS_AL_DATE[3:0]: reg_rd = al_date_r;
            OFS_INT_CFG[3:0]: reg_rd = int_cfg_r;
            OFS_WDOG[3:0]:    reg_rd = wdog_r;
            OFS_OSC_CAL[3:0]: reg_rd = osc_cal_r;
            OFS_SECONDS[3:0]: reg_rd = sec_r;
            OFS_MINUTES[3:0]: reg_rd = min_r;
            OFS_HOURS[3:0]:   reg_rd = hour_r;
            OFS_WEEKDAY[3:0]: reg_rd = wday_r;
            OFS_DATE[3:0]:    reg_rd = date_r;
            OFS_MONTH[3:0]:   reg_rd = month_r;
            default:          reg_rd = year_r;
        endcase
    end

    // data pins driven only while selected, reading, and output enabled
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dq_out <= 8'h00;
            dq_oe  <= 1'b0;
        end else begin
            dq_out <= top16 ? reg_rd : mem_rd;
            dq_oe  <= selected & pin_s_r.we_n & ~pin_s_r.oe_n;
        end
    end

    // ***************************************************************
    // assertions
    // ***************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_addr_capture: assert property (ce_fall |=> addr_lat_r == $past(pin_s_r.addr))
        else $error("address not captured at select edge");
    a_addr_hold: assert property (!ce_fall |=> $stable(addr_lat_r))
        else $error("latched address moved during access");
    a_idle_nowrite: assert property (pin_q_r.ce_n
                                     |=> $stable(user_r) && $stable(int_cfg_r))
        else $error("write while deselected");
    a_oe_release: assert property (pin_s_r.oe_n |=> !dq_oe)
        else $error("data driven with output enable high");
    a_standby_hiz: assert property (pin_s_r.ce_n [*2] |-> !dq_oe)
        else $error("data driven in standby");
    a_write_array: assert property (wr_go && !top16
                                    |-> mem_wr.en ##2 mem_rd == $past(wdat, 2))
        else $error("array write missed");
    a_reg_decode: assert property (wr_go && top16 && ridx == OFS_USER[3:0]
                                   |-> !mem_wr.en ##1 user_r == $past(wdat))
        else $error("register write reached array");
    a_irq_gate: assert property (!irq_cond ##1 $stable(int_cfg_r) |-> !int_act)
        else $error("interrupt active without enabled source");
    a_irq_drive: assert property (irq_cond ##1 $stable(int_cfg_r) |-> int_act)
        else $error("interrupt pin not asserted");
    a_sec_wrap: assert property (tick_apply && sec_r == BCD_59 |=> sec_r == RST_ZERO)
        else $error("seconds failed to wrap");
    a_leap_feb: assert property (c_day && month_r == 8'h02 && date_r == 8'h28 && leap
                                 |=> date_r == 8'h29)
        else $error("leap day skipped");
    a_wd_reset: assert property (wd_to_rst |=> !proc_rst_n [*2])
        else $error("watchdog reset pulse missing");

    c_read: cover property (selected && dq_oe && !top16);
    c_write_reg: cover property (reg_we);
    c_alarm: cover property (set_af);
    c_wd_reset: cover property (wd_to_rst);
endmodule : brtc_host_port
`default_nettype wire

// file: hw/brtc_mem.sv
`timescale 1ns/100ps
`default_nettype none
module brtc_mem (
    // clock
    input  wire  logic                           clk_sys,
    // write side
    input  wire  brtc_pkg::brtc_wr_t             wr,
    // read side
    input  wire  logic [brtc_pkg::ADDR_W-1:0]    rd_addr,
    output logic       [brtc_pkg::DATA_W-1:0]    rd_data_r
);
    import brtc_pkg::*;

    // array has no reset: it stands for the nonvolatile cells
    logic [DATA_W-1:0] cells [MEM_DEPTH];

    // one write port, registered read port
    always_ff @(posedge clk_sys) begin
        if (wr.en) begin
            cells[wr.addr] <= wr.data;
        end
        rd_data_r <= cells[rd_addr];
    end
endmodule : brtc_mem
`default_nettype wire

// file: hw/brtc_pkg.sv
`default_nettype none
package brtc_pkg;
    // ***************************************************************
    // widths and address map
    // ***************************************************************
    localparam int          ADDR_W       = 15;
    localparam int          DATA_W       = 8;
    localparam int          MEM_DEPTH    = 32768;  // top 16 locations never used as array
    localparam logic [10:0] REG_PAGE     = 11'h7FF;  // addr[14:4] of the register block
    localparam logic [14:0] OFS_FLAGS    = 15'h7FF0;
    localparam logic [14:0] OFS_USER     = 15'h7FF1;
    localparam logic [14:0] OFS_AL_SEC   = 15'h7FF2;
    localparam logic [14:0] OFS_AL_MIN   = 15'h7FF3;
    localparam logic [14:0] OFS_AL_HOUR  = 15'h7FF4;
    localparam logic [14:0] OFS_AL_DATE  = 15'h7FF5;
    localparam logic [14:0] OFS_INT_CFG  = 15'h7FF6;
    localparam logic [14:0] OFS_WDOG     = 15'h7FF7;
    localparam logic [14:0] OFS_OSC_CAL  = 15'h7FF8;
    localparam logic [14:0] OFS_SECONDS  = 15'h7FF9;
    localparam logic [14:0] OFS_MINUTES  = 15'h7FFA;
    localparam logic [14:0] OFS_HOURS    = 15'h7FFB;
    localparam logic [14:0] OFS_WEEKDAY  = 15'h7FFC;
    localparam logic [14:0] OFS_DATE     = 15'h7FFD;
    localparam logic [14:0] OFS_MONTH    = 15'h7FFE;
    localparam logic [14:0] OFS_YEAR     = 15'h7FFF;

    // ***************************************************************
    // field positions
    // ***************************************************************
    localparam int BIT_WDF      = 7;  // flags: watchdog fired
    localparam int BIT_AF       = 6;  // flags: alarm matched
    localparam int BIT_PF       = 5;  // flags: power fail seen
    localparam int BIT_CF       = 4;  // flags: century rollover
    localparam int BIT_WR_HALT  = 1;  // flags: W, stop clock updates
    localparam int BIT_WD_IRQ_EN = 7;  // int cfg: watchdog_irq_enable
    localparam int BIT_AL_IRQ_EN = 6;  // int cfg: alarm_irq_enable
    localparam int BIT_PF_IRQ_EN = 5;  // int cfg: power_fail_irq_enable
    localparam int BIT_HI_LO    = 3;  // int cfg: 1 = active high push-pull
    localparam int BIT_WD_STRB  = 7;  // wdog: watchdog_strobe
    localparam int BIT_OSC_OFF  = 7;  // osc cal: oscillator disable
    localparam int BIT_NO_MATCH = 7;  // alarm regs: field ignored

    // ***************************************************************
    // storage masks, unused bits read zero
    // ***************************************************************
    localparam logic [7:0] MASK_FLAGS_SW = 8'h0F;
    localparam logic [7:0] MASK_AL_HD    = 8'hBF;
    localparam logic [7:0] MASK_INT_CFG  = 8'hFC;
    localparam logic [7:0] MASK_WDOG     = 8'h7F;
    localparam logic [7:0] MASK_OSC_CAL  = 8'h9F;
    localparam logic [7:0] MASK_SEC_MIN  = 8'h7F;
    localparam logic [7:0] MASK_HR_DATE  = 8'h3F;
    localparam logic [7:0] MASK_WEEKDAY  = 8'h07;
    localparam logic [7:0] MASK_MONTH    = 8'h1F;

    // ***************************************************************
    // reset values and calendar limits (packed bcd)
    // ***************************************************************
    localparam logic [7:0] RST_ZERO    = 8'h00;
    localparam logic [7:0] RST_ONE     = 8'h01;
    localparam logic [7:0] BCD_59      = 8'h59;
    localparam logic [7:0] BCD_23      = 8'h23;
    localparam logic [7:0] BCD_12      = 8'h12;
    localparam logic [7:0] BCD_99      = 8'h99;
    localparam logic [7:0] DAY_LAST    = 8'h07;

    // ***************************************************************
    // timing
    // ***************************************************************
    localparam int         CLK_PERIOD_PS = 8000;
    localparam int         PROC_RST_NS   = 1000;  // least width of reset pulse
    localparam int         PROC_RST_CYC  = (PROC_RST_NS * 1000 + CLK_PERIOD_PS - 1)
                                           / CLK_PERIOD_PS;
    localparam logic [7:0] PROC_RST_LOAD = 8'(PROC_RST_CYC);

    // ***************************************************************
    // carriers
    // ***************************************************************
    typedef struct packed {
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq;
        logic              sec_tick;
        logic              pwr_fail;
    } brtc_pins_t;

    typedef struct packed {
        logic              en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } brtc_wr_t;
endpackage : brtc_pkg
`default_nettype wire

// file: tb/brtc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ***************************************************************
// host bus master model
// ***************************************************************
module brtc_host_model (
    // clock and data returned by the port
    input  wire  logic                        clk_sys,
    input  wire  logic [brtc_pkg::DATA_W-1:0] dq_out,
    input  wire  logic                        dq_oe,
    // strobes, address and data driven toward the port
    output logic                              ce_n,
    output logic                              oe_n,
    output logic                              we_n,
    output logic       [brtc_pkg::ADDR_W-1:0] addr,
    output logic       [brtc_pkg::DATA_W-1:0] dq
);
    // idle bus at time zero
    initial begin
        ce_n = 1'b1;
        oe_n = 1'b1;
        we_n = 1'b1;
        addr = 15'h0000;
        dq   = 8'h00;
    end
    // strobes while deselected; dq here is what the host leaves on the bus
    task automatic strobes(input logic w, input logic o, input logic [7:0] d);
        @(negedge clk_sys) we_n <= w;
        oe_n <= o;
        dq   <= d;
    endtask : strobes
    // byte write; address is scrambled once latched, a stale bus shows the inverse
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        @(negedge clk_sys) ce_n <= 1'b0;
        addr <= a;
        repeat (4) @(negedge clk_sys);
        addr <= ~a;
        we_n <= 1'b0;
        dq   <= d;
        repeat (7) @(negedge clk_sys);
        we_n <= 1'b1;
        repeat (3) @(negedge clk_sys);
        ce_n <= 1'b1;
        dq   <= ~d;
        repeat (4) @(negedge clk_sys);
    endtask : wr
    // byte read with write enable held high
    task automatic rd(input logic [14:0] a, output logic [7:0] d, output logic oe);
        @(negedge clk_sys) ce_n <= 1'b0;
        oe_n <= 1'b0;
        addr <= a;
        repeat (4) @(negedge clk_sys);
        addr <= ~a;
        repeat (4) @(negedge clk_sys);
        d  = dq_out;
        oe = dq_oe;
        oe_n <= 1'b1;
        ce_n <= 1'b1;
        repeat (5) @(negedge clk_sys);
    endtask : rd
endmodule : brtc_host_model
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import brtc_pkg::*;
    logic             clk_sys, rst_n, ce_n, oe_n, we_n, dq_oe, oe, pwr_fail;
    logic             int_out, int_oe, proc_rst_n, sec_tick;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq, dq_out;
    int               miscompares = 0;
    int               comparisons = 0;
    // ***************************************************************
    // clock, port and host
    // ***************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    brtc_host_port dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .address_lines(addr), .dq_in(dq), .dq_out(dq_out), .dq_oe(dq_oe),
        .sec_tick(sec_tick), .pwr_fail(pwr_fail), .int_out(int_out), .int_oe(int_oe),
        .proc_rst_n(proc_rst_n));
    brtc_host_model host (.clk_sys(clk_sys), .dq_out(dq_out), .dq_oe(dq_oe),
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr), .dq(dq));
    // ***************************************************************
    // helpers
    // ***************************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // read, then the pins must be released once output enable is gone
    task automatic rdc(input logic [14:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d, oe);
        chk(d, exp);
        chk({7'h00, oe, dq_oe}, 8'h02);
    endtask : rdc
    task automatic t_reset;
        chk({4'h0, dq_oe, int_out, int_oe, proc_rst_n}, 8'h01);
        rdc(OFS_MONTH, 8'h01);
    endtask : t_reset
    task automatic t_array;
        host.wr(15'h7FEF, 8'h3C);
        host.wr(15'h0000, 8'hA5);
        rdc(15'h7FEF, 8'h3C);
        rdc(15'h0000, 8'hA5);
    endtask : t_array
    // strobes toggled while deselected must do nothing
    task automatic t_desel;
        host.strobes(1'b0, 1'b0, 8'h55);
        repeat (8) @(negedge clk_sys);
        chk({7'h00, dq_oe}, 8'h00);
        host.strobes(1'b1, 1'b1, 8'hAA);
        rdc(OFS_YEAR, 8'h00);
    endtask : t_desel
    task automatic t_regs;
        host.wr(OFS_USER, 8'h5A);
        host.wr(OFS_WEEKDAY, 8'hFF);
        host.wr(OFS_SECONDS, 8'hC9);
        rdc(OFS_USER, 8'h5A);
        rdc(OFS_WEEKDAY, 8'h07);
        rdc(OFS_SECONDS, 8'h49);
        rdc(15'h7FEF, 8'h3C);
    endtask : t_regs
    // power fail routed to the pin in both drive styles
    task automatic t_irq;
        host.wr(OFS_INT_CFG, 8'h28);
        chk({6'h00, int_out, int_oe}, 8'h01);
        @(negedge clk_sys) pwr_fail <= 1'b1;
        repeat (6) @(negedge clk_sys);
        chk({6'h00, int_out, int_oe}, 8'h03);
        host.wr(OFS_INT_CFG, 8'h20);
        chk({6'h00, int_out, int_oe}, 8'h01);
        host.wr(OFS_INT_CFG, 8'h00);
        chk({6'h00, int_out, int_oe}, 8'h00);
    endtask : t_irq
    // one tick rolls a leap february day, hits the alarm and fires the watchdog
    task automatic t_tick;
        host.wr(OFS_YEAR, 8'h24);
        host.wr(OFS_MONTH, 8'h02);
        host.wr(OFS_DATE, 8'h28);
        host.wr(OFS_HOURS, 8'h23);
        host.wr(OFS_MINUTES, 8'h59);
        host.wr(OFS_SECONDS, 8'h59);
        host.wr(OFS_AL_DATE, 8'h29);
        host.wr(OFS_WDOG, 8'h81);
        @(negedge clk_sys) sec_tick <= 1'b1;
        repeat (6) @(negedge clk_sys);
        sec_tick <= 1'b0;
        chk({7'h00, proc_rst_n}, 8'h00);
        rdc(OFS_DATE, 8'h29);
        rdc(OFS_MONTH, 8'h02);
        rdc(OFS_HOURS, 8'h00);
        rdc(OFS_SECONDS, 8'h00);
        rdc(OFS_WEEKDAY, 8'h01);
        rdc(OFS_WDOG, 8'h01);
        rdc(OFS_FLAGS, 8'hE0);
        rdc(OFS_FLAGS, 8'h00);
        repeat (60) @(negedge clk_sys);
        chk({7'h00, proc_rst_n}, 8'h01);
    endtask : t_tick
    task automatic final_report;
        if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report
    // ***************************************************************
    // sequence and hang guard
    // ***************************************************************
    initial begin
        rst_n    = 1'b0;
        pwr_fail = 1'b0;
        sec_tick = 1'b0;
        repeat (8) @(negedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(negedge clk_sys);
        t_reset;
        t_array;
        t_desel;
        t_regs;
        t_irq;
        t_tick;
        final_report;
    end
    initial begin
        #50000;
        miscompares++;
        final_report;
    end
endmodule : testbench
`default_nettype wire
